// ==== logic/nvm_protect_pkg.sv ====
// Summary of operation
// - Sixty-four guard bits, one per memory block, in two 32-bit set registers.
// - Erase or write hitting a guarded block is blocked; only a CPU request also hard-faults the CPU.
// - CPU whole-memory erase while any block is guarded is blocked and faults.
// - All guard bits are cleared to unguarded by reset.
// - Only reset clears guard bits; software writes never clear them.
// - Guard checks are suspended when a debugger is attached and override selects disable.
// - Peripheral class register: one bit per group, 0 region 0, 1 region 1, reset 0.
// - RAM below base plus region-0 length is region 0, all other RAM region 1.
package nvm_protect_pkg;
    localparam int ADDR_W = 12;
    localparam int BLOCKS = 64;
    localparam int BLK_W = 6;
    localparam logic [ADDR_W-1:0] OFF_PERIPH_CLASS = 12'h528;
    localparam logic [ADDR_W-1:0] OFF_RAM_LEN = 12'h52C;
    localparam logic [ADDR_W-1:0] OFF_PROT_LOW = 12'h600;
    localparam logic [ADDR_W-1:0] OFF_PROT_HIGH = 12'h604;
    localparam logic [ADDR_W-1:0] OFF_OVERRIDE = 12'h608;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h700;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 12'h704;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 12'h708;
    localparam logic [31:0] PERIPH_CLASS_RESET = 32'h00000000;
    localparam logic [31:0] PERIPH_CLASS_MASK = 32'hC00FFFDF;
    localparam logic [31:0] RAM_LEN_RESET = 32'h00000000;
    localparam logic [31:0] OVERRIDE_RESET = 32'h00000001;
    localparam int OVERRIDE_BIT = 0;
    localparam logic OVERRIDE_DISABLE = 1'b0;
    localparam int IRQ_BIT_BLOCK = 0;
    localparam int IRQ_BIT_ERASE_ALL = 1;
    localparam int IRQ_W = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== logic/axil_reg_slave.sv ====
`timescale 1ns/1ps
// AXI4-Lite slave front end: one access of each kind; a write is answered one cycle after capture, a read on its handshake edge.
module axil_reg_slave (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [nvm_protect_pkg::ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [nvm_protect_pkg::ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic wr_en_out,
    output logic [nvm_protect_pkg::ADDR_W-1:0] wr_addr_out,
    output logic [31:0] wr_data_out,
    output logic [3:0] wr_strb_out,
    input wire logic wr_ok_in,
    output logic [nvm_protect_pkg::ADDR_W-1:0] rd_addr_out,
    input wire logic [31:0] rd_data_in,
    input wire logic rd_ok_in
);
    logic aw_held;
    logic w_held;
    logic [nvm_protect_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
    assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
    assign s_axi_arready_out = !s_axi_rvalid_out;
    assign wr_en_out = aw_held && w_held && !s_axi_bvalid_out;
    assign wr_addr_out = aw_addr;
    assign wr_data_out = w_data;
    assign wr_strb_out = w_strb;
    assign rd_addr_out = s_axi_araddr_in;

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_in;
        end else if (wr_en_out) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
        end else if (wr_en_out) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= nvm_protect_pkg::RESP_OKAY;
        end else if (wr_en_out) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_ok_in ? nvm_protect_pkg::RESP_OKAY : nvm_protect_pkg::RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= '0;
            s_axi_rresp_out <= nvm_protect_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_ok_in ? rd_data_in : 32'h00000000;
            s_axi_rresp_out <= rd_ok_in ? nvm_protect_pkg::RESP_OKAY : nvm_protect_pkg::RESP_SLVERR;
        end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end
endmodule // axil_reg_slave

// ==== logic/guard_bit_bank.sv ====
`timescale 1ns/1ps
// Set-only guard bits; a write can only raise bits, reset is the sole way down.
module guard_bit_bank (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic set_low_in,
    input wire logic set_high_in,
    input wire logic [31:0] set_data_in,
    output logic [nvm_protect_pkg::BLOCKS-1:0] guard_out
);
    genvar i;
    generate
        for (i = 0; i < nvm_protect_pkg::BLOCKS; i = i + 1) begin : g_bit
            logic hit;
            if (i < 32) begin : g_lo
                assign hit = set_low_in && set_data_in[i];
            end else begin : g_hi
                assign hit = set_high_in && set_data_in[i-32];
            end
            always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    guard_out[i] <= 1'b0;
                end else if (hit) begin
                    guard_out[i] <= 1'b1;
                end
            end
        end
    endgenerate

    sticky_bits_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        ($past(guard_out) & ~guard_out) == 64'h0)
        else $error("guard bit fell without reset");
endmodule // guard_bit_bank

// ==== logic/nvm_block_write_protect.sv ====
`timescale 1ns/1ps
// Guard logic for the non-volatile memory, with region classification registers.
// Access checks are combinational so the memory controller can block in the same cycle.
module nvm_block_write_protect (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [nvm_protect_pkg::ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [nvm_protect_pkg::ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic nvm_req_in,
    input wire logic nvm_req_cpu_in,
    input wire logic nvm_req_erase_all_in,
    input wire logic [nvm_protect_pkg::BLK_W-1:0] nvm_req_block_in,
    output logic nvm_req_block_out,
    output logic hard_fault_out,
    input wire logic debug_attached_in,
    input wire logic [31:0] ram_base_address_in,
    input wire logic [31:0] ram_probe_addr_in,
    output logic ram_probe_region1_out,
    output logic [31:0] periph_class_out,
    output logic irq_out
);
    logic wr_en;
    logic [nvm_protect_pkg::ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [nvm_protect_pkg::ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic [31:0] peripheral_region_class;
    logic [31:0] ram_region0_length;
    logic [31:0] debug_protect_override;
    logic [nvm_protect_pkg::BLOCKS-1:0] block_guard_bit;
    logic [nvm_protect_pkg::IRQ_W-1:0] irq_status;
    logic [nvm_protect_pkg::IRQ_W-1:0] irq_enable;
    logic checks_on;
    logic any_guard;
    logic block_hit;
    logic erase_all_hit;
    logic [31:0] wmask;
    logic [32:0] ram_limit;

    axil_reg_slave u_bus (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .s_axi_awaddr_in(s_axi_awaddr_in),
        .s_axi_awvalid_in(s_axi_awvalid_in),
        .s_axi_awready_out(s_axi_awready_out),
        .s_axi_wdata_in(s_axi_wdata_in),
        .s_axi_wstrb_in(s_axi_wstrb_in),
        .s_axi_wvalid_in(s_axi_wvalid_in),
        .s_axi_wready_out(s_axi_wready_out),
        .s_axi_bresp_out(s_axi_bresp_out),
        .s_axi_bvalid_out(s_axi_bvalid_out),
        .s_axi_bready_in(s_axi_bready_in),
        .s_axi_araddr_in(s_axi_araddr_in),
        .s_axi_arvalid_in(s_axi_arvalid_in),
        .s_axi_arready_out(s_axi_arready_out),
        .s_axi_rdata_out(s_axi_rdata_out),
        .s_axi_rresp_out(s_axi_rresp_out),
        .s_axi_rvalid_out(s_axi_rvalid_out),
        .s_axi_rready_in(s_axi_rready_in),
        .wr_en_out(wr_en),
        .wr_addr_out(wr_addr),
        .wr_data_out(wr_data),
        .wr_strb_out(wr_strb),
        .wr_ok_in(wr_ok),
        .rd_addr_out(rd_addr),
        .rd_data_in(rd_data),
        .rd_ok_in(rd_ok)
    );

    assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

    // Byte strobes gate the set bits so a partial write touches only its lanes.
    guard_bit_bank u_guard (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .set_low_in(wr_en && wr_addr == nvm_protect_pkg::OFF_PROT_LOW),
        .set_high_in(wr_en && wr_addr == nvm_protect_pkg::OFF_PROT_HIGH),
        .set_data_in(wr_data & wmask),
        .guard_out(block_guard_bit)
    );

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            peripheral_region_class <= nvm_protect_pkg::PERIPH_CLASS_RESET;
        end else if (wr_en && wr_addr == nvm_protect_pkg::OFF_PERIPH_CLASS) begin
            peripheral_region_class <= ((peripheral_region_class & ~wmask) | (wr_data & wmask))
                & nvm_protect_pkg::PERIPH_CLASS_MASK;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ram_region0_length <= nvm_protect_pkg::RAM_LEN_RESET;
        end else if (wr_en && wr_addr == nvm_protect_pkg::OFF_RAM_LEN) begin
            ram_region0_length <= (ram_region0_length & ~wmask) | (wr_data & wmask);
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            debug_protect_override <= nvm_protect_pkg::OVERRIDE_RESET;
        end else if (wr_en && wr_addr == nvm_protect_pkg::OFF_OVERRIDE && wr_strb[0]) begin
            debug_protect_override <= {31'h00000000, wr_data[nvm_protect_pkg::OVERRIDE_BIT]};
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_enable <= '0;
        end else if (wr_en && wr_addr == nvm_protect_pkg::OFF_IRQ_ENABLE && wr_strb[0]) begin
            irq_enable <= wr_data[nvm_protect_pkg::IRQ_W-1:0];
        end
    end

    // A new fault event wins over a clear in the same cycle.
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_status <= '0;
        end else begin
            for (int i = 0; i < nvm_protect_pkg::IRQ_W; i++) begin
                if ((i == nvm_protect_pkg::IRQ_BIT_BLOCK && block_hit) ||
                    (i == nvm_protect_pkg::IRQ_BIT_ERASE_ALL && erase_all_hit)) begin
                    irq_status[i] <= 1'b1;
                end else if (wr_en && wr_addr == nvm_protect_pkg::OFF_IRQ_CLEAR &&
                             wr_strb[0] && wr_data[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
        end
    end

    assign irq_out = |(irq_status & irq_enable);

    // Override only bites while a debugger is attached.
    assign checks_on = !(debug_attached_in &&
        debug_protect_override[nvm_protect_pkg::OVERRIDE_BIT] == nvm_protect_pkg::OVERRIDE_DISABLE);
    assign any_guard = |block_guard_bit;
    assign block_hit = nvm_req_in && !nvm_req_erase_all_in && checks_on &&
        block_guard_bit[nvm_req_block_in];
    assign erase_all_hit = nvm_req_in && nvm_req_erase_all_in && nvm_req_cpu_in &&
        checks_on && any_guard;
    assign nvm_req_block_out = block_hit || erase_all_hit;
    assign hard_fault_out = (block_hit || erase_all_hit) && nvm_req_cpu_in;

    // Alignment of base plus length is left to software; the compare is exact.
    assign ram_limit = {1'b0, ram_base_address_in} + {1'b0, ram_region0_length};
    assign ram_probe_region1_out = !({1'b0, ram_probe_addr_in} < ram_limit);
    assign periph_class_out = peripheral_region_class;

    // The status register is read-only and unmapped offsets answer with an error.
    always_comb begin
        wr_ok = 1'b1;
        unique case (wr_addr)
            nvm_protect_pkg::OFF_PROT_LOW,
            nvm_protect_pkg::OFF_PROT_HIGH: wr_ok = 1'b1;
            nvm_protect_pkg::OFF_PERIPH_CLASS,
            nvm_protect_pkg::OFF_RAM_LEN,
            nvm_protect_pkg::OFF_OVERRIDE,
            nvm_protect_pkg::OFF_IRQ_ENABLE,
            nvm_protect_pkg::OFF_IRQ_CLEAR: wr_ok = 1'b1;
            nvm_protect_pkg::OFF_IRQ_STATUS: wr_ok = 1'b0;
            default: wr_ok = 1'b0;
        endcase
    end

    always_comb begin
        rd_data = 32'h00000000;
        rd_ok = 1'b1;
        unique case (rd_addr)
            nvm_protect_pkg::OFF_PERIPH_CLASS: rd_data = peripheral_region_class;
            nvm_protect_pkg::OFF_RAM_LEN: rd_data = ram_region0_length;
            nvm_protect_pkg::OFF_PROT_LOW: rd_data = block_guard_bit[31:0];
            nvm_protect_pkg::OFF_PROT_HIGH: rd_data = block_guard_bit[63:32];
            nvm_protect_pkg::OFF_OVERRIDE: rd_data = debug_protect_override;
            nvm_protect_pkg::OFF_IRQ_STATUS: rd_data = {30'h00000000, irq_status};
            nvm_protect_pkg::OFF_IRQ_ENABLE: rd_data = {30'h00000000, irq_enable};
            nvm_protect_pkg::OFF_IRQ_CLEAR: rd_data = 32'h00000000;
            default: rd_ok = 1'b0;
        endcase
    end

    sequence guarded_write_s;
        nvm_req_in && !nvm_req_erase_all_in && nvm_req_cpu_in && checks_on &&
            block_guard_bit[nvm_req_block_in];
    endsequence

    guarded_block_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        guarded_write_s |-> nvm_req_block_out && hard_fault_out ##1 irq_status[0])
        else $error("guarded block write not blocked");

    erase_all_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        nvm_req_in && nvm_req_erase_all_in && nvm_req_cpu_in && checks_on && any_guard
        |-> hard_fault_out ##1 irq_status[1])
        else $error("erase all not blocked");

    free_block_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        nvm_req_in && !nvm_req_erase_all_in && !block_guard_bit[nvm_req_block_in]
        |-> !nvm_req_block_out)
        else $error("unguarded block blocked");

    debug_off_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        debug_attached_in && !debug_protect_override[0] |-> !nvm_req_block_out)
        else $error("checks active under debug disable");

    no_debug_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        !debug_attached_in && nvm_req_in && !nvm_req_erase_all_in && nvm_req_cpu_in &&
        block_guard_bit[nvm_req_block_in] |-> hard_fault_out)
        else $error("override acted without debugger");

    guard_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        wr_en && wr_addr == nvm_protect_pkg::OFF_PROT_HIGH && wr_strb[3] && wr_data[31]
        |=> block_guard_bit[63])
        else $error("high set write did not guard block");

    guard_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        $fell(block_guard_bit[0]) |-> 1'b0)
        else $error("guard bit cleared by software");

    ram_region_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        ram_probe_addr_in == ram_base_address_in && ram_region0_length == 32'h00000000
        |-> ram_probe_region1_out)
        else $error("empty region 0 misclassified");

    class_reset_a: assert property (@(posedge sys_clk_in)
        $rose(rst_b_in) |-> peripheral_region_class == 32'h00000000 && block_guard_bit == 64'h0)
        else $error("state not cleared by reset");
endmodule // nvm_block_write_protect

// ==== verification/nvm_access_source.sv ====
`timescale 1ns/1ps
// CPU or debugger side of the memory: presents one erase or write request per command cycle.
module nvm_access_source (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic cmd_valid_in,
    input wire logic cmd_cpu_in,
    input wire logic cmd_erase_all_in,
    input wire logic [nvm_protect_pkg::BLK_W-1:0] cmd_block_in,
    output logic req_out,
    output logic req_cpu_out,
    output logic req_erase_all_out,
    output logic [nvm_protect_pkg::BLK_W-1:0] req_block_out
);
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            req_out <= 1'b0;
            req_cpu_out <= 1'b0;
            req_erase_all_out <= 1'b0;
            req_block_out <= 6'h00;
        end else if (cmd_valid_in) begin
            req_out <= 1'b1;
            req_cpu_out <= cmd_cpu_in;
            req_erase_all_out <= cmd_erase_all_in;
            req_block_out <= cmd_block_in;
        end else begin
            // Qualifiers toggle while idle so a stale request value is never relied upon.
            req_out <= 1'b0;
            req_cpu_out <= ~req_cpu_out;
            req_erase_all_out <= ~req_erase_all_out;
            req_block_out <= ~req_block_out;
        end
    end
endmodule // nvm_access_source

// ==== verification/test_nvm_block_write_protect.sv ====
`timescale 1ns/1ps
module test_nvm_block_write_protect;
    localparam logic [31:0] RAM_BASE = 32'h20000000;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000, probe = 32'h00000000, pclass, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, blocked, fault, region1, irq;
    logic [1:0] bresp, rresp;
    logic cmd_valid = 1'b0, cmd_cpu = 1'b0, cmd_ea = 1'b0, dbg = 1'b0;
    logic req, req_cpu, req_ea;
    logic [5:0] cmd_blk = 6'h00, req_blk;
    int err_total = 0;
    int n_tests = 0;

    always #2 sys_clk = ~sys_clk;

    nvm_access_source src (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .cmd_valid_in(cmd_valid),
        .cmd_cpu_in(cmd_cpu), .cmd_erase_all_in(cmd_ea), .cmd_block_in(cmd_blk),
        .req_out(req), .req_cpu_out(req_cpu), .req_erase_all_out(req_ea),
        .req_block_out(req_blk));

    nvm_block_write_protect dut (.sys_clk_in(sys_clk), .rst_b_in(rst_b),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .nvm_req_in(req),
        .nvm_req_cpu_in(req_cpu), .nvm_req_erase_all_in(req_ea), .nvm_req_block_in(req_blk),
        .nvm_req_block_out(blocked), .hard_fault_out(fault), .debug_attached_in(dbg),
        .ram_base_address_in(RAM_BASE), .ram_probe_addr_in(probe),
        .ram_probe_region1_out(region1), .periph_class_out(pclass), .irq_out(irq));

    task automatic bad(input logic [31:0] g, input logic [31:0] e);
        err_total++;
        $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
    endtask

    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) bad(g, e);
    endtask

    task automatic chk2(input logic [1:0] g, input logic [1:0] e);
        n_tests++;
        if (g !== e) bad({30'h0, g}, {30'h0, e});
    endtask

    task automatic chk1(input logic g, input logic e);
        n_tests++;
        if (g !== e) bad({31'h0, g}, {31'h0, e});
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                chk2(bresp, er);
                bready <= 1'b0;
                break;
            end
        end
        if (i == 64) bad(32'h0, 32'h1);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int i;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                chk32(rdata, e);
                chk2(rresp, er);
                rready <= 1'b0;
                break;
            end
        end
        if (i == 64) bad(32'h0, 32'h1);
    endtask

    // One request cycle from the source, then the combinational verdict is judged.
    task automatic nvm_try(input logic cpu, input logic ea, input logic [5:0] b,
                           input logic eb, input logic ef);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_cpu <= cpu;
        cmd_ea <= ea;
        cmd_blk <= b;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        #1;
        chk1(blocked, eb);
        chk1(fault, ef);
    endtask

    task automatic t_reset();
        rd(nvm_protect_pkg::OFF_PROT_LOW, 32'h00000000, 2'h0);
        rd(nvm_protect_pkg::OFF_PROT_HIGH, 32'h00000000, 2'h0);
        rd(nvm_protect_pkg::OFF_PERIPH_CLASS, 32'h00000000, 2'h0);
        rd(nvm_protect_pkg::OFF_RAM_LEN, 32'h00000000, 2'h0);
        rd(nvm_protect_pkg::OFF_OVERRIDE, 32'h00000001, 2'h0);
        nvm_try(1'b1, 1'b1, 6'h00, 1'b0, 1'b0);
    endtask

    task automatic t_guard();
        wr(nvm_protect_pkg::OFF_PROT_LOW, 32'h00000001, 2'h0);
        wr(nvm_protect_pkg::OFF_PROT_HIGH, 32'h80000000, 2'h0);
        wr(nvm_protect_pkg::OFF_PROT_LOW, 32'h00000000, 2'h0);
        rd(nvm_protect_pkg::OFF_PROT_LOW, 32'h00000001, 2'h0);
        rd(nvm_protect_pkg::OFF_PROT_HIGH, 32'h80000000, 2'h0);
        nvm_try(1'b1, 1'b0, 6'd0, 1'b1, 1'b1);
        nvm_try(1'b1, 1'b0, 6'd63, 1'b1, 1'b1);
        nvm_try(1'b1, 1'b0, 6'd1, 1'b0, 1'b0);
        nvm_try(1'b1, 1'b0, 6'd32, 1'b0, 1'b0);
        nvm_try(1'b0, 1'b0, 6'd0, 1'b1, 1'b0);
        nvm_try(1'b1, 1'b1, 6'd5, 1'b1, 1'b1);
        nvm_try(1'b0, 1'b1, 6'd5, 1'b0, 1'b0);
    endtask

    task automatic t_debug();
        @(posedge sys_clk);
        dbg <= 1'b1;
        nvm_try(1'b1, 1'b0, 6'd0, 1'b1, 1'b1);
        wr(nvm_protect_pkg::OFF_OVERRIDE, {31'h0, nvm_protect_pkg::OVERRIDE_DISABLE}, 2'h0);
        nvm_try(1'b1, 1'b0, 6'd63, 1'b0, 1'b0);
        @(posedge sys_clk);
        dbg <= 1'b0;
        nvm_try(1'b1, 1'b0, 6'd63, 1'b1, 1'b1);
    endtask

    task automatic t_region();
        wr(nvm_protect_pkg::OFF_PERIPH_CLASS, 32'hFFFFFFFF, 2'h0);
        rd(nvm_protect_pkg::OFF_PERIPH_CLASS, 32'hC00FFFDF, 2'h0);
        chk32(pclass, 32'hC00FFFDF);
        @(posedge sys_clk);
        probe <= RAM_BASE;
        @(posedge sys_clk);
        chk1(region1, 1'b1);
        wr(nvm_protect_pkg::OFF_RAM_LEN, 32'h00000100, 2'h0);
        @(posedge sys_clk);
        probe <= RAM_BASE + 32'h000000FC;
        @(posedge sys_clk);
        chk1(region1, 1'b0);
        probe <= RAM_BASE + 32'h00000100;
        @(posedge sys_clk);
        chk1(region1, 1'b1);
    endtask

    task automatic t_irq();
        rd(nvm_protect_pkg::OFF_IRQ_STATUS, 32'h00000003, 2'h0);
        wr(nvm_protect_pkg::OFF_IRQ_ENABLE, 32'h00000001, 2'h0);
        repeat (3) @(posedge sys_clk);
        chk1(irq, 1'b1);
        wr(nvm_protect_pkg::OFF_IRQ_CLEAR, 32'h00000001, 2'h0);
        repeat (3) @(posedge sys_clk);
        chk1(irq, 1'b0);
        rd(nvm_protect_pkg::OFF_IRQ_STATUS, 32'h00000002, 2'h0);
        wr(nvm_protect_pkg::OFF_IRQ_STATUS, 32'h00000003, nvm_protect_pkg::RESP_SLVERR);
        wr(12'h7FC, 32'h12345678, nvm_protect_pkg::RESP_SLVERR);
        rd(12'h7FC, 32'h00000000, nvm_protect_pkg::RESP_SLVERR);
    endtask

    task automatic t_rereset();
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(nvm_protect_pkg::OFF_PROT_LOW, 32'h00000000, 2'h0);
        rd(nvm_protect_pkg::OFF_PROT_HIGH, 32'h00000000, 2'h0);
        nvm_try(1'b1, 1'b0, 6'd63, 1'b0, 1'b0);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset();
        t_guard();
        t_debug();
        t_region();
        t_irq();
        t_rereset();
        summarize();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        summarize();
    end
endmodule // test_nvm_block_write_protect
